// ---- design/rpeoc_pkg.sv ----
// Package of constants and types for the reference priority and Ethernet output register bank
package rpeoc_pkg;

    // Register byte addresses on the configuration port
    localparam logic [7:0] RPEOC_ADDR_IN3_PRIO = 8'h1A;
    localparam logic [7:0] RPEOC_ADDR_IN4_PRIO = 8'h1B;
    localparam logic [7:0] RPEOC_ADDR_ENET_OUT = 8'h1C;

    // Values after reset, one per priority path for inputs 3 and 4, then the Ethernet, PLL and read data values
    localparam logic [7:0] RPEOC_IN3_RESET_T0 = 8'h00;
    localparam logic [7:0] RPEOC_IN3_RESET_T4 = 8'h00;
    localparam logic [7:0] RPEOC_IN4_RESET_T0 = 8'h05;
    localparam logic [7:0] RPEOC_IN4_RESET_T4 = 8'h00;
    localparam logic [7:0] RPEOC_ENET_RESET = 8'h00;
    localparam logic RPEOC_PLL_ON_RESET = 1'h1;
    localparam logic [7:0] RPEOC_RD_RESET = 8'h00;

    // Storable bits of each register; the rest always read zero
    localparam logic [7:0] RPEOC_IN3_MASK = 8'hF0;
    localparam logic [7:0] RPEOC_IN4_MASK = 8'h0F;
    localparam logic [7:0] RPEOC_ENET_MASK = 8'hF6;

    // Field positions
    localparam int RPEOC_RANK_W = 4;
    localparam int RPEOC_IN3_RANK_LSB = 4;
    localparam int RPEOC_IN4_RANK_LSB = 0;
    localparam int RPEOC_SYNC_BIT = 7;
    localparam int RPEOC_PLL_OFF_BIT = 6;
    localparam int RPEOC_OUT1_BIT = 5;
    localparam int RPEOC_OUT4_BIT = 4;
    localparam int RPEOC_OUT3_BIT = 2;
    localparam int RPEOC_OUT2_BIT = 1;
    localparam logic [3:0] RPEOC_RANK_OFF = 4'h0;

    // Result of comparing the two ranks of one path
    typedef enum logic [1:0] {
        RPEOC_PICK_NONE,
        RPEOC_PICK_IN3,
        RPEOC_PICK_IN4
    } rpeoc_pick_t;

    // Configuration port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rpeoc_bus_req_t;

    // Ethernet output controls seen by the clock generators
    typedef struct packed {
        logic sync_align;
        logic pll_on;
        logic out1_ethernet_select;
        logic out2_ethernet_select;
        logic out3_ethernet_select;
        logic out4_ethernet_select;
    } rpeoc_enet_out_t;

    // Full state of the register bank
    typedef struct packed {
        logic [7:0] in3_t0;
        logic [7:0] in3_t4;
        logic [7:0] in4_t0;
        logic [7:0] in4_t4;
        logic [7:0] enet;
        logic pll_on;
        logic [7:0] rd_data;
    } rpeoc_top_state_t;

    // State of one rank evaluator
    typedef struct packed {
        rpeoc_pick_t pick;
    } rpeoc_eval_state_t;

    // A rank of zero takes the input out of automatic selection
    function automatic logic rpeoc_rank_available(input logic [3:0] rank);
        return rank != RPEOC_RANK_OFF;
    endfunction

endpackage

// ---- design/rpeoc_rank_eval.sv ----
// Registered comparison of the input 3 and input 4 ranks of one selection path
`timescale 1ns/1ps
`default_nettype none

module rpeoc_rank_eval
    import rpeoc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [3:0] rank_in3, // Rank of input 3
    input wire logic [3:0] rank_in4, // Rank of input 4
    output rpeoc_pick_t pick // Preferred input, registered
);

    rpeoc_eval_state_t state_reg;
    rpeoc_eval_state_t state_next;
    logic avail3;
    logic avail4;

    // Availability of each input
    assign avail3 = rpeoc_rank_available(rank_in3);
    assign avail4 = rpeoc_rank_available(rank_in4);

    // Lower nonzero rank wins; a tie goes to input 3
    always_comb begin
        state_next = state_reg;
        if (avail3 && (!avail4 || rank_in3 <= rank_in4)) begin
            state_next.pick = RPEOC_PICK_IN3;
        end else if (avail4) begin
            state_next.pick = RPEOC_PICK_IN4;
        end else begin
            state_next.pick = RPEOC_PICK_NONE;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.pick <= RPEOC_PICK_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pick = state_reg.pick;

    // Both ranks zero leaves nothing to pick
    AST_EVAL_NONE: assert property (@(posedge clk) disable iff (rst)
        (rank_in3 == 4'h0 && rank_in4 == 4'h0) |=> pick == RPEOC_PICK_NONE)
        else $error("pick not none with both ranks zero");

    // A better nonzero input 4 rank picks input 4
    AST_EVAL_IN4: assert property (@(posedge clk) disable iff (rst)
        (rank_in4 != 4'h0 && (rank_in3 == 4'h0 || rank_in4 < rank_in3))
        |=> pick == RPEOC_PICK_IN4)
        else $error("input 4 not picked with better rank");

endmodule

`default_nettype wire

// ---- design/rpeoc_top.sv ----
// Register bank for input 3/4 priorities and Ethernet output configuration
`timescale 1ns/1ps
`default_nettype none

module rpeoc_top
    import rpeoc_pkg::*;
(
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire rpeoc_bus_req_t bus_req, // Address, write data and strobes
    input wire logic path_view_select, // 0 reaches path T0 priorities, 1 path T4
    output logic [7:0] rd_data, // Read data, valid the cycle after a read
    output rpeoc_enet_out_t enet_out, // Ethernet output controls
    output logic [3:0] input3_rank_t0, // Input 3 rank for path T0
    output logic [3:0] input3_rank_t4, // Input 3 rank for path T4
    output logic [3:0] input4_rank_t0, // Input 4 rank for path T0
    output logic [3:0] input4_rank_t4, // Input 4 rank for path T4
    output rpeoc_pick_t pick_t0, // Preferred input on path T0
    output rpeoc_pick_t pick_t4 // Preferred input on path T4
);

    rpeoc_top_state_t state_reg;
    rpeoc_top_state_t state_next;

    // Keeps only the storable bits of a written byte
    function automatic logic [7:0] keep_bits(input logic [7:0] data, input logic [7:0] mask);
        return data & mask;
    endfunction

    // Register writes, path steering and read answer
    always_comb begin
        state_next = state_reg;
        state_next.rd_data = RPEOC_RD_RESET;
        if (bus_req.wr) begin
            case (bus_req.addr)
                RPEOC_ADDR_IN3_PRIO: begin
                    if (path_view_select) begin
                        state_next.in3_t4 = keep_bits(bus_req.wdata, RPEOC_IN3_MASK);
                    end else begin
                        state_next.in3_t0 = keep_bits(bus_req.wdata, RPEOC_IN3_MASK);
                    end
                end
                RPEOC_ADDR_IN4_PRIO: begin
                    if (path_view_select) begin
                        state_next.in4_t4 = keep_bits(bus_req.wdata, RPEOC_IN4_MASK);
                    end else begin
                        state_next.in4_t0 = keep_bits(bus_req.wdata, RPEOC_IN4_MASK);
                    end
                end
                RPEOC_ADDR_ENET_OUT: begin
                    state_next.enet = keep_bits(bus_req.wdata, RPEOC_ENET_MASK);
                    state_next.pll_on = ~bus_req.wdata[RPEOC_PLL_OFF_BIT];
                end
                default: begin
                end
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                RPEOC_ADDR_IN3_PRIO: begin
                    state_next.rd_data = path_view_select ? state_reg.in3_t4 : state_reg.in3_t0;
                end
                RPEOC_ADDR_IN4_PRIO: begin
                    state_next.rd_data = path_view_select ? state_reg.in4_t4 : state_reg.in4_t0;
                end
                RPEOC_ADDR_ENET_OUT: begin
                    state_next.rd_data = state_reg.enet;
                end
                default: begin
                    state_next.rd_data = RPEOC_RD_RESET;
                end
            endcase
        end
    end

    // State register with reset values
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.in3_t0 <= RPEOC_IN3_RESET_T0;
            state_reg.in3_t4 <= RPEOC_IN3_RESET_T4;
            state_reg.in4_t0 <= RPEOC_IN4_RESET_T0;
            state_reg.in4_t4 <= RPEOC_IN4_RESET_T4;
            state_reg.enet <= RPEOC_ENET_RESET;
            state_reg.pll_on <= RPEOC_PLL_ON_RESET;
            state_reg.rd_data <= RPEOC_RD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs taken straight from the state register
    assign rd_data = state_reg.rd_data;
    assign input3_rank_t0 = state_reg.in3_t0[RPEOC_IN3_RANK_LSB +: RPEOC_RANK_W];
    assign input3_rank_t4 = state_reg.in3_t4[RPEOC_IN3_RANK_LSB +: RPEOC_RANK_W];
    assign input4_rank_t0 = state_reg.in4_t0[RPEOC_IN4_RANK_LSB +: RPEOC_RANK_W];
    assign input4_rank_t4 = state_reg.in4_t4[RPEOC_IN4_RANK_LSB +: RPEOC_RANK_W];

    // Ethernet output controls
    assign enet_out.sync_align = state_reg.enet[RPEOC_SYNC_BIT];
    assign enet_out.pll_on = state_reg.pll_on;
    assign enet_out.out1_ethernet_select = state_reg.enet[RPEOC_OUT1_BIT];
    assign enet_out.out4_ethernet_select = state_reg.enet[RPEOC_OUT4_BIT];
    assign enet_out.out3_ethernet_select = state_reg.enet[RPEOC_OUT3_BIT];
    assign enet_out.out2_ethernet_select = state_reg.enet[RPEOC_OUT2_BIT];

    // Preferred input for each selection path
    rpeoc_rank_eval u_eval_t0 (
        .clk(clk),
        .rst(rst),
        .rank_in3(input3_rank_t0),
        .rank_in4(input4_rank_t0),
        .pick(pick_t0)
    );

    rpeoc_rank_eval u_eval_t4 (
        .clk(clk),
        .rst(rst),
        .rank_in3(input3_rank_t4),
        .rank_in4(input4_rank_t4),
        .pick(pick_t4)
    );

    // Checks on the register bank
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Helper: decoded write strobes
    logic wr_in3;
    logic wr_in4;
    logic wr_enet;
    assign wr_in3 = bus_req.wr && bus_req.addr == RPEOC_ADDR_IN3_PRIO;
    assign wr_in4 = bus_req.wr && bus_req.addr == RPEOC_ADDR_IN4_PRIO;
    assign wr_enet = bus_req.wr && bus_req.addr == RPEOC_ADDR_ENET_OUT;

    // Input 3 rank on path T0 follows a write and spares path T4
    AST_IN3_RANK_WRITE: assert property (
        (wr_in3 && !path_view_select)
        |=> input3_rank_t0 == $past(bus_req.wdata[7:4]) && $stable(input3_rank_t4))
        else $error("input 3 rank on path T0 not written");

    // Unused nibbles always read back as zero
    AST_UNUSED_NIBBLES: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN3_PRIO) ##1 1'h1
        |-> rd_data[3:0] == 4'h0 && input4_rank_t0 == state_reg.in4_t0[3:0]
            && state_reg.in4_t0[7:4] == 4'h0 && state_reg.in4_t4[7:4] == 4'h0)
        else $error("unused priority bits not zero");

    // Input 4 rank on path T4 follows a write and reads back the same
    AST_IN4_RANK_T4: assert property (
        (wr_in4 && path_view_select) ##1
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN4_PRIO && path_view_select
            && !bus_req.wr)
        |=> rd_data == {4'h0, $past(bus_req.wdata[3:0], 2)})
        else $error("input 4 rank on path T4 read back wrong");

    // Sync alignment bit tracks the written value
    AST_SYNC_ALIGN: assert property (
        wr_enet |=> enet_out.sync_align == $past(bus_req.wdata[7]))
        else $error("sync alignment not updated");

    // Output 1 source select tracks bit 5
    AST_OUT1_SELECT: assert property (
        wr_enet |=> enet_out.out1_ethernet_select == $past(bus_req.wdata[5]))
        else $error("output 1 select not updated");

    // Output 4 source select tracks bit 4
    AST_OUT4_SELECT: assert property (
        wr_enet |=> enet_out.out4_ethernet_select == $past(bus_req.wdata[4]))
        else $error("output 4 select not updated");

    // Outputs 3 and 2 track bits 2 and 1; bits 3 and 0 read zero
    AST_OUT23_SELECT: assert property (
        wr_enet |=> enet_out.out3_ethernet_select == $past(bus_req.wdata[2])
            && enet_out.out2_ethernet_select == $past(bus_req.wdata[1])
            && state_reg.enet[3] == 1'h0 && state_reg.enet[0] == 1'h0)
        else $error("outputs 3 or 2 select wrong");

    // PLL enable is the inverse of the written bit 6
    AST_PLL_ACTIVE_LOW: assert property (
        wr_enet |=> enet_out.pll_on != $past(bus_req.wdata[6]))
        else $error("PLL enable polarity wrong");

    // Read data stands one cycle only
    AST_RD_ONE_CYCLE: assert property (
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data held beyond its cycle");

    // Ethernet controls hold while that register is not written
    AST_ENET_HOLD: assert property (
        !wr_enet |=> $stable(enet_out))
        else $error("Ethernet controls changed without a write");

    // A write to an unmapped address changes nothing
    AST_UNMAPPED_WRITE: assert property (
        (bus_req.wr && !wr_in3 && !wr_in4 && !wr_enet)
        |=> $stable(state_reg.in3_t0) && $stable(state_reg.in4_t0) && $stable(state_reg.enet))
        else $error("unmapped write changed a register");

    // Input 3 rank on path T4 follows a write and spares path T0
    AST_IN3_RANK_T4: assert property (
        (wr_in3 && path_view_select)
        |=> input3_rank_t4 == $past(bus_req.wdata[7:4]) && $stable(input3_rank_t0))
        else $error("input 3 rank on path T4 not written");

    // Input 4 rank on path T0 follows a write and spares path T4
    AST_IN4_RANK_T0: assert property (
        (wr_in4 && !path_view_select)
        |=> input4_rank_t0 == $past(bus_req.wdata[3:0]) && $stable(input4_rank_t4))
        else $error("input 4 rank on path T0 not written");

    // Unused nibbles are never stored on either path
    AST_UNUSED_STORED: assert property (
        state_reg.in3_t0[3:0] == 4'h0 && state_reg.in3_t4[3:0] == 4'h0
            && state_reg.in4_t0[7:4] == 4'h0 && state_reg.in4_t4[7:4] == 4'h0)
        else $error("unused priority bits stored");

    // Input 3 register on path T0 reads back its rank over a zero low nibble
    AST_READ_IN3_T0: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN3_PRIO && !path_view_select)
        |=> rd_data == {$past(input3_rank_t0), 4'h0})
        else $error("input 3 path T0 read back wrong");

    // Input 3 register on path T4 reads back its rank over a zero low nibble
    AST_READ_IN3_T4: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN3_PRIO && path_view_select)
        |=> rd_data == {$past(input3_rank_t4), 4'h0})
        else $error("input 3 path T4 read back wrong");

    // Input 4 register on path T0 reads back its rank under a zero high nibble
    AST_READ_IN4_T0: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN4_PRIO && !path_view_select)
        |=> rd_data == {4'h0, $past(input4_rank_t0)})
        else $error("input 4 path T0 read back wrong");

    // Input 4 register on path T4 reads back its rank under a zero high nibble
    AST_READ_IN4_T4: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_IN4_PRIO && path_view_select)
        |=> rd_data == {4'h0, $past(input4_rank_t4)})
        else $error("input 4 path T4 read back wrong");

    // Ethernet register reads back the controls that it drives
    AST_READ_ENET: assert property (
        (bus_req.rd && bus_req.addr == RPEOC_ADDR_ENET_OUT)
        |=> rd_data[7] == $past(enet_out.sync_align) && rd_data[6] != $past(enet_out.pll_on)
            && rd_data[5] == $past(enet_out.out1_ethernet_select)
            && rd_data[4] == $past(enet_out.out4_ethernet_select)
            && rd_data[2] == $past(enet_out.out3_ethernet_select)
            && rd_data[1] == $past(enet_out.out2_ethernet_select)
            && rd_data[3] == 1'h0 && rd_data[0] == 1'h0)
        else $error("Ethernet register read back wrong");

    // Ranks change only on a priority write
    AST_PRIO_HOLD: assert property (
        !(wr_in3 || wr_in4)
        |=> $stable(input3_rank_t0) && $stable(input3_rank_t4)
            && $stable(input4_rank_t0) && $stable(input4_rank_t4))
        else $error("rank changed without a write");

    // An unmapped read answers zero
    AST_UNMAPPED_READ: assert property (
        (bus_req.rd && bus_req.addr != RPEOC_ADDR_IN3_PRIO
            && bus_req.addr != RPEOC_ADDR_IN4_PRIO && bus_req.addr != RPEOC_ADDR_ENET_OUT)
        |=> rd_data == 8'h00)
        else $error("unmapped read returned data");

    // Reset puts every register at its value after reset
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> input3_rank_t0 == RPEOC_IN3_RESET_T0[7:4]
            && input3_rank_t4 == RPEOC_IN3_RESET_T4[7:4]
            && input4_rank_t0 == RPEOC_IN4_RESET_T0[3:0]
            && input4_rank_t4 == RPEOC_IN4_RESET_T4[3:0]
            && enet_out.pll_on == RPEOC_PLL_ON_RESET
            && enet_out.sync_align == RPEOC_ENET_RESET[RPEOC_SYNC_BIT]
            && rd_data == RPEOC_RD_RESET)
        else $error("register not at reset value");

    // Scenario: Ethernet register written then read back
    COV_ENET_WRITE_READ: cover property (
        wr_enet ##1 (bus_req.rd && bus_req.addr == RPEOC_ADDR_ENET_OUT));

    // Scenario: input 4 preferred on path T0
    COV_PICK_IN4: cover property (pick_t0 == RPEOC_PICK_IN4);

    // Scenario: both paths written back to back
    COV_BOTH_PATHS: cover property (
        (wr_in3 && !path_view_select) ##1 (wr_in3 && path_view_select));

    // Scenario: PLL switched off
    COV_PLL_OFF: cover property (wr_enet ##1 !enet_out.pll_on);

    // Scenario: equal nonzero ranks on path T0 settle on input 3
    COV_PICK_TIE: cover property (
        (input3_rank_t0 == input4_rank_t0 && input3_rank_t0 != 4'h0) ##1 pick_t0 == RPEOC_PICK_IN3);

endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the priority and Ethernet output register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rpeoc_pkg::*;

    logic clk;
    logic rst;
    rpeoc_bus_req_t bus_req;
    logic path_view_select;
    logic [7:0] rd_data;
    rpeoc_enet_out_t enet_out;
    logic [3:0] input3_rank_t0;
    logic [3:0] input3_rank_t4;
    logic [3:0] input4_rank_t0;
    logic [3:0] input4_rank_t4;
    rpeoc_pick_t pick_t0;
    rpeoc_pick_t pick_t4;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] rv;

    rpeoc_top u_rpeoc_top (
        .clk(clk),
        .rst(rst),
        .bus_req(bus_req),
        .path_view_select(path_view_select),
        .rd_data(rd_data),
        .enet_out(enet_out),
        .input3_rank_t0(input3_rank_t0),
        .input3_rank_t4(input3_rank_t4),
        .input4_rank_t0(input4_rank_t0),
        .input4_rank_t4(input4_rank_t4),
        .pick_t0(pick_t0),
        .pick_t4(pick_t4)
    );

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Ends the run with the counts and the verdict
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    // Compare of byte-wide results
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare of a selection result
    task automatic chk_pick(input string name, input rpeoc_pick_t exp, input rpeoc_pick_t got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare of the Ethernet control outputs against a register value
    task automatic chk_enet(input logic [7:0] v);
        rpeoc_enet_out_t e;
        e = '{sync_align: v[7], pll_on: ~v[6], out1_ethernet_select: v[5],
              out2_ethernet_select: v[1], out3_ethernet_select: v[2],
              out4_ethernet_select: v[4]};
        cmp_count++;
        if (enet_out !== e) begin
            err_total++;
            $display("unexpected enet_out expected %h seen %h", e, enet_out);
        end
    endtask

    // One-cycle write, called just after an edge so strobes can follow with no gap
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic sel);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        path_view_select <= sel;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    // One-cycle read, called just after an edge; data is taken in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, input logic sel, output logic [7:0] d);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        path_view_select <= sel;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask

    // Reset values of every register, with input 3 checked on path T0 only
    task automatic test_reset();
        repeat (2) @(posedge clk);
        #1;
        chk("in3_t0", 8'h00, {4'h0, input3_rank_t0});
        chk("in4_t0", 8'h05, {4'h0, input4_rank_t0});
        chk("in4_t4", 8'h00, {4'h0, input4_rank_t4});
        chk_pick("pick_t0", RPEOC_PICK_IN4, pick_t0);
        chk_pick("pick_t4", RPEOC_PICK_NONE, pick_t4);
        chk_enet(8'h00);
        bus_read(RPEOC_ADDR_IN4_PRIO, 1'b0, rv);
        chk("rd_in4_t0", 8'h05, rv);
        bus_read(RPEOC_ADDR_IN4_PRIO, 1'b1, rv);
        chk("rd_in4_t4", 8'h00, rv);
        bus_read(RPEOC_ADDR_ENET_OUT, 1'b0, rv);
        chk("rd_enet", 8'h00, rv);
        $display("test reset done");
    endtask

    // Rank fields, unused halves and path steering
    task automatic test_ranks();
        bus_write(RPEOC_ADDR_IN3_PRIO, 8'hFF, 1'b0);
        chk("in3_t0", 8'h0F, {4'h0, input3_rank_t0});
        chk("in3_t4", 8'h00, {4'h0, input3_rank_t4});
        bus_write(RPEOC_ADDR_IN3_PRIO, 8'h3A, 1'b1);
        chk("in3_t0_kept", 8'h0F, {4'h0, input3_rank_t0});
        bus_read(RPEOC_ADDR_IN3_PRIO, 1'b0, rv);
        chk("rd_in3_t0", 8'hF0, rv);
        bus_read(RPEOC_ADDR_IN3_PRIO, 1'b1, rv);
        chk("rd_in3_t4", 8'h30, rv);
        chk("in3_t4", 8'h03, {4'h0, input3_rank_t4});
        bus_write(RPEOC_ADDR_IN4_PRIO, 8'hFF, 1'b1);
        chk("in4_t4", 8'h0F, {4'h0, input4_rank_t4});
        chk("in4_t0", 8'h05, {4'h0, input4_rank_t0});
        bus_read(RPEOC_ADDR_IN4_PRIO, 1'b1, rv);
        chk("rd_in4_t4", 8'h0F, rv);
        $display("test ranks done");
    endtask

    // Preference between the two inputs, zero rank and equal ranks
    task automatic test_pick();
        repeat (2) @(posedge clk);
        #1;
        chk_pick("pick_t4_3v15", RPEOC_PICK_IN3, pick_t4);
        chk_pick("pick_t0_15v5", RPEOC_PICK_IN4, pick_t0);
        bus_write(RPEOC_ADDR_IN4_PRIO, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk_pick("pick_t0_in4off", RPEOC_PICK_IN3, pick_t0);
        bus_write(RPEOC_ADDR_IN3_PRIO, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk_pick("pick_t0_none", RPEOC_PICK_NONE, pick_t0);
        bus_write(RPEOC_ADDR_IN3_PRIO, 8'h20, 1'b0);
        bus_write(RPEOC_ADDR_IN4_PRIO, 8'h01, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk_pick("pick_t0_1v2", RPEOC_PICK_IN4, pick_t0);
        bus_write(RPEOC_ADDR_IN3_PRIO, 8'h10, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk_pick("pick_t0_tie", RPEOC_PICK_IN3, pick_t0);
        $display("test pick done");
    endtask

    // Every Ethernet register bit alone, then all at once from the other path
    task automatic test_enet();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            bus_write(RPEOC_ADDR_ENET_OUT, v, 1'b0);
            chk_enet(v);
            bus_read(RPEOC_ADDR_ENET_OUT, 1'b0, rv);
            chk("rd_enet", v & 8'hF6, rv);
        end
        bus_write(RPEOC_ADDR_ENET_OUT, 8'hFF, 1'b1);
        chk_enet(8'hFF);
        bus_read(RPEOC_ADDR_ENET_OUT, 1'b0, rv);
        chk("rd_enet_all", 8'hF6, rv);
        $display("test enet done");
    endtask

    // Unmapped address and the one-cycle life of read data
    task automatic test_unmapped();
        bus_write(8'h1D, 8'h00, 1'b0);
        chk_enet(8'hFF);
        bus_read(8'h1D, 1'b0, rv);
        chk("rd_unmapped", 8'h00, rv);
        bus_read(RPEOC_ADDR_IN4_PRIO, 1'b0, rv);
        chk("rd_in4_t0", 8'h01, rv);
        @(posedge clk);
        #1;
        chk("rd_after", 8'h00, rd_data);
        $display("test unmapped done");
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        path_view_select = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_ranks();
        test_pick();
        test_enet();
        test_unmapped();
        final_report();
    end

endmodule
`default_nettype wire
